// ### spe_pkg.sv
// Constants shared by the slave parameter error latch.
// Assumes one 100 MHz clock and a 16-bit remote register word.
package spe_pkg;
    // ========================================
    // Register words (documented index)
    localparam int unsigned REG_LATEST_ERROR_CODE = 0;
    localparam int unsigned REG_LATEST_ERROR_SLAVE_ID = 1;
    localparam int unsigned WORD_W = 16;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // ========================================
    // Error codes
    localparam logic [15:0] CODE_HW_FAULT_A = 16'h012C;
    localparam logic [15:0] CODE_HW_FAULT_B = 16'h012D;
    localparam logic [15:0] CODE_TARGET_ID = 16'h012E;
    localparam logic [15:0] CODE_VALUE_REJECT = 16'h012F;
    localparam logic [15:0] CODE_ACCESS_FAIL = 16'h0130;
    localparam logic [15:0] CODE_SLAVE_STATUS = 16'h0131;
    localparam logic [15:0] CODE_DUP_ID = 16'h0190;
    localparam logic [15:0] CODE_NO_ID = 16'h0191;
    localparam logic [15:0] ID_NONE = 16'h0FFF;
    // ========================================
    // Duplicate alarm entry
    localparam logic [7:0] ALARM_COUNT_ONE = 8'h01;
    localparam logic [7:0] ALARM_COUNT_RESET = 8'h00;
    // ========================================
    // Input conditioning
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic FLAG_RESET = 1'b0;
endpackage : spe_pkg

// ### spe_sync_if.sv
// Carries a conditioned level and its rising edge between modules.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
`default_nettype none
interface spe_sync_if;
    logic level;
    logic rise;
    modport producer (output level, output rise);
    modport consumer (input level, input rise);
endinterface : spe_sync_if
`default_nettype wire

// ### spe_sync.sv
// Three-stage input conditioner with agreement filter and edge pulse.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module spe_sync #(
    parameter int unsigned STAGES = spe_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Pin side
    input wire logic i_async,
    // Conditioned side
    spe_sync_if.producer o_sync
);
    logic [STAGES-1:0] chain_q;
    logic level_q;
    logic rise_q;

    // ========================================
    // Synchroniser chain; stage 0 feeds stage 1 only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            chain_q <= '0;
        end else if (i_clk_en) begin
            chain_q <= {chain_q[STAGES-2:0], i_async};
        end
    end

    // ========================================
    // A change counts once the last two stages agree
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else if (i_clk_en) begin
            rise_q <= 1'b0;
            if (chain_q[STAGES-1] == chain_q[STAGES-2]) begin
                level_q <= chain_q[STAGES-1];
                rise_q <= chain_q[STAGES-1] & ~level_q;
            end
        end
    end

    assign o_sync.level = level_q;
    assign o_sync.rise = rise_q;
endmodule : spe_sync
`default_nettype wire

// ### spe_err_latch.sv
// Error capture and latch for slave parameter access and address faults.
// Assumes fault pulses come from logic on i_clock; the clear request is remote.
// ========================================
// Summary of operation
// - hardware fault stores 012C/012D, ID, alarm
// - bad target ID stores 012E, 0FFF, alarm
// - rejected value stores 012F, ID, alarm
// - failed access stores 0130, ID, access flag
// - bad slave status stores 0131, ID, alarm
// - duplicate address stores 0190, ID, alarm
// - unset address stores code 0191
// - newest error overwrites older code and ID
// - flags and words stay after cause clears
// - clear toggle drops alarm, zeroes both words
// - clear toggle also drops access error flag
// - duplicate check only during address detection
// - duplicate flag never halts bit transmission
// - duplicate entry count one, duplicated ID
// - duplicate status lost on slave power loss
// - alarm and access flags hold until clear request goes on
`timescale 1ns/1ps
`default_nettype none
module spe_err_latch (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Host remote I/O
    input wire logic i_error_clear_request,
    // Fault events, one-cycle pulses
    input wire logic i_hw_fault,
    input wire logic i_hw_fault_kind,
    input wire logic i_target_id_invalid,
    input wire logic i_value_rejected,
    input wire logic i_access_failed,
    input wire logic i_slave_status_bad,
    input wire logic i_dup_found,
    input wire logic i_unset_found,
    input wire logic [15:0] i_fault_id,
    // Address detection, slave power and transmit halt
    input wire logic i_addr_detect_active,
    input wire logic i_slave_power_lost,
    input wire logic i_tx_halt_request,
    // Status flags
    output logic o_slave_alarm,
    output logic o_param_access_error,
    output logic o_dup_status,
    // Remote register words
    output logic [15:0] o_latest_error_code_word,
    output logic [15:0] o_latest_error_slave_id_word,
    // Duplicate alarm entry
    output logic [7:0] o_alarm_id_count,
    output logic [15:0] o_alarm_id,
    // Slave line
    output logic o_bit_tx_enable
);
    // ========================================
    // Clear request conditioning
    spe_sync_if clr_if ();

    spe_sync #(
        .STAGES(spe_pkg::SYNC_STAGES)
    ) u_clr_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_async(i_error_clear_request),
        .o_sync(clr_if.producer)
    );

    logic clear_pulse;
    // Held request does not keep wiping new errors
    assign clear_pulse = clr_if.rise;

    // ========================================
    // Fault classification
    logic dup_event;
    logic any_event;
    logic alarm_event;
    logic [15:0] code_d;
    logic [15:0] id_d;

    // Duplicates only exist while detection runs
    assign dup_event = i_dup_found & i_addr_detect_active;

    // Later lines win when faults coincide in one cycle
    always_comb begin
        any_event = 1'b0;
        alarm_event = 1'b0;
        code_d = spe_pkg::WORD_RESET;
        id_d = spe_pkg::WORD_RESET;
        if (i_hw_fault) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = i_hw_fault_kind ? spe_pkg::CODE_HW_FAULT_B
                                     : spe_pkg::CODE_HW_FAULT_A;
            id_d = i_fault_id;
        end
        if (i_target_id_invalid) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = spe_pkg::CODE_TARGET_ID;
            id_d = spe_pkg::ID_NONE;
        end
        if (i_value_rejected) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = spe_pkg::CODE_VALUE_REJECT;
            id_d = i_fault_id;
        end
        if (i_access_failed) begin
            any_event = 1'b1;
            code_d = spe_pkg::CODE_ACCESS_FAIL;
            id_d = i_fault_id;
        end
        if (i_slave_status_bad) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = spe_pkg::CODE_SLAVE_STATUS;
            id_d = i_fault_id;
        end
        if (dup_event) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = spe_pkg::CODE_DUP_ID;
            id_d = i_fault_id;
        end
        if (i_unset_found) begin
            any_event = 1'b1;
            alarm_event = 1'b1;
            code_d = spe_pkg::CODE_NO_ID;
            id_d = i_fault_id;
        end
    end

    // ========================================
    // Latest error words; a new error beats a same-cycle clear
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_latest_error_code_word <= spe_pkg::WORD_RESET;
            o_latest_error_slave_id_word <= spe_pkg::WORD_RESET;
        end else if (i_clk_en) begin
            if (any_event) begin
                o_latest_error_code_word <= code_d;
                o_latest_error_slave_id_word <= id_d;
            end else if (clear_pulse) begin
                o_latest_error_code_word <= spe_pkg::WORD_RESET;
                o_latest_error_slave_id_word <= spe_pkg::WORD_RESET;
            end
        end
    end

    // ========================================
    // Slave alarm flag; only the clear edge drops it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_slave_alarm <= spe_pkg::FLAG_RESET;
        end else if (i_clk_en) begin
            if (alarm_event) begin
                o_slave_alarm <= 1'b1;
            end else if (clear_pulse) begin
                o_slave_alarm <= 1'b0;
            end
        end
    end

    // ========================================
    // Parameter access error flag
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_param_access_error <= spe_pkg::FLAG_RESET;
        end else if (i_clk_en) begin
            if (i_access_failed) begin
                o_param_access_error <= 1'b1;
            end else if (clear_pulse) begin
                o_param_access_error <= 1'b0;
            end
        end
    end

    // ========================================
    // Duplicate status and its single alarm entry
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_dup_status <= spe_pkg::FLAG_RESET;
            o_alarm_id_count <= spe_pkg::ALARM_COUNT_RESET;
            o_alarm_id <= spe_pkg::WORD_RESET;
        end else if (i_clk_en) begin
            if (dup_event) begin
                o_dup_status <= 1'b1;
                o_alarm_id_count <= spe_pkg::ALARM_COUNT_ONE;
                o_alarm_id <= i_fault_id;
            end else if (i_slave_power_lost || clear_pulse) begin
                // Slave power loss forgets it until detection reruns
                o_dup_status <= 1'b0;
                o_alarm_id_count <= spe_pkg::ALARM_COUNT_RESET;
                o_alarm_id <= spe_pkg::WORD_RESET;
            end
        end
    end

    // ========================================
    // Bit transmission; duplicate status takes no part
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_bit_tx_enable <= 1'b0;
        end else if (i_clk_en) begin
            o_bit_tx_enable <= ~i_tx_halt_request;
        end
    end

    // ========================================
    // Checks
    sequence clear_seen_s;
        i_clk_en && clear_pulse && !any_event;
    endsequence

    sequence quiet_s;
        i_clk_en && !any_event && !clear_pulse;
    endsequence

    hw_fault_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_hw_fault && !i_target_id_invalid && !i_value_rejected
         && !i_access_failed && !i_slave_status_bad && !dup_event && !i_unset_found)
        |=> o_latest_error_code_word == ($past(i_hw_fault_kind) ? spe_pkg::CODE_HW_FAULT_B
            : spe_pkg::CODE_HW_FAULT_A) && o_slave_alarm
            && o_latest_error_slave_id_word == $past(i_fault_id))
        else $error("hardware fault not latched");

    target_id_word_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_target_id_invalid && !i_value_rejected && !i_access_failed
         && !i_slave_status_bad && !dup_event && !i_unset_found)
        |=> o_latest_error_code_word == spe_pkg::CODE_TARGET_ID
            && o_latest_error_slave_id_word == spe_pkg::ID_NONE && o_slave_alarm)
        else $error("target ID error not latched");

    access_flag_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_access_failed && !alarm_event && !o_slave_alarm)
        |=> o_param_access_error && !o_slave_alarm
            && o_latest_error_code_word == spe_pkg::CODE_ACCESS_FAIL)
        else $error("access error flag wrong");

    dup_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_dup_found && !i_addr_detect_active && !o_dup_status
         && !i_unset_found && !i_hw_fault && !i_value_rejected && !i_access_failed
         && !i_slave_status_bad && !i_target_id_invalid && !clear_pulse)
        |=> !o_dup_status && $stable(o_latest_error_code_word))
        else $error("duplicate taken outside detection");

    dup_entry_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && dup_event)
        |=> o_dup_status && o_alarm_id_count == spe_pkg::ALARM_COUNT_ONE
            && o_alarm_id == $past(i_fault_id))
        else $error("duplicate entry wrong");

    hold_latched_a: assert property (@(posedge i_clock) disable iff (i_rst)
        quiet_s ##1 quiet_s |=> $stable(o_latest_error_code_word)
            && $stable(o_slave_alarm) && $stable(o_param_access_error))
        else $error("latched state moved without cause");

    clear_words_a: assert property (@(posedge i_clock) disable iff (i_rst)
        clear_seen_s |=> o_latest_error_code_word == spe_pkg::WORD_RESET
            && o_latest_error_slave_id_word == spe_pkg::WORD_RESET
            && !o_param_access_error)
        else $error("clear did not empty words");

    clear_once_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && clear_pulse) |=> !clear_pulse)
        else $error("clear acted twice");

    tx_not_halted_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && !i_tx_halt_request && o_dup_status) |=> o_bit_tx_enable)
        else $error("duplicate halted transmission");

    power_loss_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_slave_power_lost && !dup_event) |=> !o_dup_status)
        else $error("duplicate survived power loss");
endmodule : spe_err_latch
`default_nettype wire

// ### spe_host_model.sv
// Host side model: drives the remote error clear request as an on/off toggle.
// Assumes the shared 100 MHz clock; the request is held long enough to pass conditioning.
`timescale 1ns/1ps
`default_nettype none
module spe_host_model (
    // Clock
    input wire logic i_clock,
    // Remote output to the device
    output logic o_error_clear_request
);
    // ========================================
    // Request driver
    initial o_error_clear_request = 1'b0;

    // Six cycles covers the conditioning delay and the minimum low time
    task automatic set_request(input logic on);
        @(posedge i_clock);
        o_error_clear_request <= on;
        repeat (6) @(posedge i_clock);
        #1;
    endtask : set_request
endmodule : spe_host_model
`default_nettype wire

// ### slave_param_error_latch_tb.sv
// Self-checking bench for the slave parameter error latch.
// Assumes spe_pkg is compiled first; the host model drives the clear request.
`timescale 1ns/1ps
`default_nettype none
module slave_param_error_latch_tb;
    // ========================================
    // Signals
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [6:0] ev = 7'h00;
    logic hw_kind = 1'b0;
    logic [15:0] fault_id = 16'h0000;
    logic detect = 1'b1;
    logic power_lost = 1'b0;
    logic tx_halt = 1'b0;
    logic clk_en = 1'b1;
    logic clear_req;
    logic alarm, acc_err, dup_st, tx_en;
    logic [15:0] code, id, alarm_id;
    logic [7:0] count;
    int num_errors = 0;
    int check_count = 0;

    always #5 i_clock = ~i_clock;

    spe_host_model host (.i_clock(i_clock), .o_error_clear_request(clear_req));

    spe_err_latch dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en),
        .i_error_clear_request(clear_req),
        .i_hw_fault(ev[0]), .i_hw_fault_kind(hw_kind), .i_target_id_invalid(ev[1]),
        .i_value_rejected(ev[2]), .i_access_failed(ev[3]), .i_slave_status_bad(ev[4]),
        .i_dup_found(ev[5]), .i_unset_found(ev[6]), .i_fault_id(fault_id),
        .i_addr_detect_active(detect), .i_slave_power_lost(power_lost),
        .i_tx_halt_request(tx_halt),
        .o_slave_alarm(alarm), .o_param_access_error(acc_err), .o_dup_status(dup_st),
        .o_latest_error_code_word(code), .o_latest_error_slave_id_word(id),
        .o_alarm_id_count(count), .o_alarm_id(alarm_id), .o_bit_tx_enable(tx_en)
    );

    // ========================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One-cycle event pulse; outputs are settled when the task returns
    task automatic fire(input int sel, input logic [15:0] fid, input logic kind);
        @(posedge i_clock);
        ev <= 7'h01 << sel;
        fault_id <= fid;
        hw_kind <= kind;
        @(posedge i_clock);
        ev <= 7'h00;
        #1;
    endtask : fire

    function automatic logic [15:0] exp_code(input int i);
        case (i)
            0: exp_code = spe_pkg::CODE_HW_FAULT_A;
            1: exp_code = spe_pkg::CODE_HW_FAULT_B;
            2: exp_code = spe_pkg::CODE_TARGET_ID;
            3: exp_code = spe_pkg::CODE_VALUE_REJECT;
            4: exp_code = spe_pkg::CODE_ACCESS_FAIL;
            5: exp_code = spe_pkg::CODE_SLAVE_STATUS;
            6: exp_code = spe_pkg::CODE_DUP_ID;
            default: exp_code = spe_pkg::CODE_NO_ID;
        endcase
    endfunction : exp_code

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // ========================================
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end

    // ========================================
    // Main sequence
    initial begin
        logic [15:0] fid;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        chk(code, spe_pkg::WORD_RESET, "code after reset");
        // Every error kind, each followed by a clear toggle
        for (int i = 0; i < 8; i++) begin
            fid = 16'h0010 + 16'(i);
            fire((i < 2) ? 0 : i - 1, fid, i == 1);
            chk(code, exp_code(i), "code");
            chk(id, (i == 2) ? spe_pkg::ID_NONE : fid, "id");
            chk(16'(alarm), 16'(i != 4), "alarm flag");
            chk(16'(acc_err), 16'(i == 4), "access flag");
            if (i == 6) begin
                chk(16'(count), 16'(spe_pkg::ALARM_COUNT_ONE), "dup count");
                chk(alarm_id, fid, "dup alarm id");
            end
            // Cause is gone, state must hold until the request goes on
            repeat (20) @(posedge i_clock);
            #1;
            chk(code, exp_code(i), "code held");
            chk(16'(alarm | acc_err), 16'h0001, "flag held");
            host.set_request(1'b1);
            chk(code, 16'h0000, "code cleared");
            chk(id, 16'h0000, "id cleared");
            chk(16'(alarm), 16'h0000, "alarm cleared");
            chk(16'(acc_err), 16'h0000, "access cleared");
            host.set_request(1'b0);
        end
        // Duplicate outside address detection is ignored
        detect <= 1'b0;
        fire(5, 16'h0030, 1'b0);
        chk(code, 16'h0000, "dup outside detect");
        chk(16'(dup_st), 16'h0000, "dup status outside detect");
        detect <= 1'b1;
        // Request held on must not clear a new error
        host.set_request(1'b1);
        fire(4, 16'h0041, 1'b0);
        repeat (10) @(posedge i_clock);
        #1;
        chk(code, spe_pkg::CODE_SLAVE_STATUS, "error during held request");
        host.set_request(1'b0);
        chk(id, 16'h0041, "id after request off");
        // Newest error overwrites
        fire(2, 16'h0021, 1'b0);
        fire(4, 16'h0022, 1'b0);
        chk(code, spe_pkg::CODE_SLAVE_STATUS, "newest code");
        chk(id, 16'h0022, "newest id");
        // Duplicate status keeps transmission running
        fire(5, 16'h000A, 1'b0);
        chk(16'(dup_st), 16'h0001, "dup status set");
        chk(16'(tx_en), 16'h0001, "tx runs with dup");
        tx_halt <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        chk(16'(tx_en), 16'h0000, "tx halted");
        tx_halt <= 1'b0;
        // Slave power loss drops duplicate status
        @(posedge i_clock);
        power_lost <= 1'b1;
        @(posedge i_clock);
        power_lost <= 1'b0;
        @(posedge i_clock);
        #1;
        chk(16'(dup_st), 16'h0000, "dup after power loss");
        // Rerun detection finds the duplicate again
        fire(5, 16'h000A, 1'b0);
        chk(16'(dup_st), 16'h0001, "dup back after rerun");
        // Power cycle acts as a clear
        fire(3, 16'h0050, 1'b0);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        chk(code, 16'h0000, "code after power cycle");
        chk(16'(acc_err), 16'h0000, "access after power cycle");
        // Clock enable low freezes every register
        clk_en <= 1'b0;
        fire(2, 16'h0060, 1'b0);
        chk(code, 16'h0000, "code frozen while disabled");
        chk(16'(alarm), 16'h0000, "alarm frozen while disabled");
        clk_en <= 1'b1;
        end_of_test();
    end
endmodule : slave_param_error_latch_tb
`default_nettype wire
